// *** src/eprom_prog_pkg.sv ***
package eprom_prog_pkg;

  // clock and programming times, each in ns
  localparam int CLK_PERIOD_NS   = 5;
  localparam int FAST_PULSE_NS   = 1000000;
  localparam int SHORT_PULSE_NS  = 100000;
  localparam int SETUP_NS        = 2000;
  localparam int HOLD_NS         = 2000;
  // output enable turn-on and turn-off allowance, plain defaults
  localparam int OE_EN_NS        = 150;
  localparam int OE_DIS_NS       = 150;

  localparam int FAST_PULSE_CYCLES  = FAST_PULSE_NS / CLK_PERIOD_NS;
  localparam int SHORT_PULSE_CYCLES = SHORT_PULSE_NS / CLK_PERIOD_NS;
  localparam int SETUP_CYCLES       = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYCLES        = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OE_EN_CYCLES       = (OE_EN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OE_DIS_CYCLES      = (OE_DIS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // widths and field positions
  localparam int CNT_W       = 20;
  localparam int ADDR_W      = 13;
  localparam int WORD_ADDR_W = 12;
  localparam int BYTE_W      = 8;
  localparam int WORD_W      = 16;
  localparam int LOCK_POS    = 7;
  localparam int PROT_A_POS  = 4;

  localparam logic [BYTE_W-1:0]  ERASED_BYTE  = 8'hff;
  localparam logic [BYTE_W-1:0]  LOCK_PULSE   = 8'h7f;
  localparam logic [ADDR_W-1:0]  PROT_ADDR    = 13'h0010;
  localparam logic [ADDR_W-1:0]  PVERIFY_ADDR = 13'h0000;
  localparam logic [WORD_W-1:0]  ZERO_WORD    = 16'h0000;

  typedef enum logic [2:0] {
    OP_READ,
    OP_WRITE,
    OP_FILL,
    OP_PROTECT,
    OP_PROTECT_VERIFY
  } op_type;

  typedef enum logic [3:0] {
    S_IDLE,
    S_RD_SETUP,
    S_RD_EN,
    S_RD_REL,
    S_PG_SETUP,
    S_PG_PULSE,
    S_PG_HOLD,
    S_PT_SETUP,
    S_PT_PULSE,
    S_PT_HOLD,
    S_DONE
  } state_type;

endpackage

// *** src/timer_if.sv ***
`timescale 1ns/1ps
interface timer_if;
  import eprom_prog_pkg::*;
  logic             start;
  logic [CNT_W-1:0] load;
  logic             done;
  modport ctrl (output start, output load, input done);
  modport tmr  (input start, input load, output done);
endinterface

// *** src/pulse_timer.sv ***
`timescale 1ns/1ps
module pulse_timer
  import eprom_prog_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  timer_if.tmr     tif
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } timer_state_type;

  timer_state_type st;
  timer_state_type next_st;

  // load on start, then count down to zero
  always_comb
  begin
    next_st = st;
    if (tif.start)
      next_st.cnt = tif.load;
    else if (st.cnt != '0)
      next_st.cnt = st.cnt - 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign tif.done = (st.cnt == '0);

endmodule

// *** src/eprom_programmer.sv ***
`timescale 1ns/1ps
module eprom_programmer
  import eprom_prog_pkg::*;
#(
  parameter int FAST_PULSE_CYC  = FAST_PULSE_CYCLES,
  parameter int SHORT_PULSE_CYC = SHORT_PULSE_CYCLES
)
(
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  input  wire logic                   cmdValid,
  output logic                        cmdReady,
  input  wire op_type                 cmdOp,
  input  wire logic [WORD_ADDR_W-1:0] cmdWordAddr,
  input  wire logic [WORD_W-1:0]      cmdWord,
  input  wire logic                   cmdShortPulse,
  output logic                        rspValid,
  output logic [WORD_W-1:0]           rspWord,
  output logic                        rspFail,
  output logic                        rspBlocked,
  output logic                        protectDone,
  output logic [ADDR_W-1:0]           byteAddressLines,
  output logic                        chipEnableN,
  output logic                        outputEnableN,
  output logic                        programStrobeN,
  output logic                        protectModeSelect,
  output logic                        highSupplyOn,
  output logic [BYTE_W-1:0]           byteLines,
  input  wire logic [BYTE_W-1:0]      byteLinesIn,
  output logic                        byteLinesOeN
);

  typedef struct packed {
    state_type              state;
    op_type                 op;
    logic [WORD_ADDR_W-1:0] word;
    logic [WORD_W-1:0]      data;
    logic [WORD_W-1:0]      rdData;
    logic [BYTE_W-1:0]      cur;
    logic [BYTE_W-1:0]      byteOut;
    logic [ADDR_W-1:0]      addr;
    logic                   lowByte;
    logic                   verifyPhase;
    logic                   algoShort;
    logic                   allVerified;
    logic                   failed;
    logic                   protDone;
    logic                   rspValid;
    logic                   rspFail;
    logic                   rspBlocked;
    logic                   ceOn;
    logic                   oeOn;
    logic                   progOn;
    logic                   protectOn;
    logic                   vppOn;
    logic                   driveOn;
  } ctrl_state_type;

  ctrl_state_type    st;
  ctrl_state_type    next_st;
  logic [BYTE_W-1:0] want;
  logic [BYTE_W-1:0] nextWant;
  logic              advance;

  timer_if tif ();

  pulse_timer u_timer (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .tif     (tif)
  );

  function automatic logic [CNT_W-1:0] waitFor(input state_type s, input logic shortP);
    int c;
    c = 1;
    case (s)
      S_RD_SETUP, S_PG_SETUP, S_PT_SETUP: c = SETUP_CYCLES;
      S_RD_EN:                            c = OE_EN_CYCLES;
      S_RD_REL:                           c = OE_DIS_CYCLES;
      S_PG_PULSE, S_PT_PULSE:             c = shortP ? SHORT_PULSE_CYC : FAST_PULSE_CYC;
      S_PG_HOLD, S_PT_HOLD:               c = HOLD_CYCLES;
      default:                            c = 1;
    endcase
    return CNT_W'(c - 1);
  endfunction

  always_comb
  begin
    next_st          = st;
    advance          = 1'b0;
    tif.start        = 1'b0;
    tif.load         = '0;
    next_st.rspValid = 1'b0;
    want             = st.lowByte ? st.data[BYTE_W-1:0] : st.data[WORD_W-1:BYTE_W];
    unique case (st.state)
      S_IDLE:
        if (cmdValid)
        begin
          next_st.op          = cmdOp;
          next_st.word        = cmdWordAddr;
          next_st.data        = (cmdOp == OP_FILL) ? ZERO_WORD : cmdWord;
          next_st.algoShort   = cmdShortPulse;
          next_st.lowByte     = 1'b0;
          next_st.verifyPhase = 1'b0;
          next_st.rspFail     = 1'b0;
          next_st.rspBlocked  = 1'b0;
          if (cmdOp == OP_PROTECT && (!st.allVerified || st.failed))
          begin
            next_st.rspFail = 1'b1;
            next_st.state   = S_DONE;
          end
          else if (cmdOp == OP_PROTECT)
            next_st.state = S_PT_SETUP;
          else
            next_st.state = S_RD_SETUP;
        end
      S_RD_SETUP:
        if (tif.done)
          next_st.state = S_RD_EN;
      S_RD_EN:
        if (tif.done)
        begin
          next_st.cur   = byteLinesIn;
          next_st.state = S_RD_REL;
        end
      S_RD_REL:
        if (tif.done)
        begin
          unique case (st.op)
            OP_READ:
            begin
              if (st.lowByte)
                next_st.rdData[BYTE_W-1:0] = st.cur;
              else
                next_st.rdData[WORD_W-1:BYTE_W] = st.cur;
              next_st.rspBlocked = st.protDone;
              advance            = 1'b1;
            end
            OP_PROTECT_VERIFY:
            begin
              next_st.protDone = !st.cur[LOCK_POS];
              next_st.rspFail  = st.cur[LOCK_POS];
              next_st.state    = S_DONE;
            end
            OP_WRITE, OP_FILL, OP_PROTECT:
              if (st.verifyPhase ? (st.cur != want) : ((st.cur & want) != want))
              begin
                next_st.failed  = 1'b1;
                next_st.rspFail = 1'b1;
                next_st.state   = S_DONE;
              end
              else if (!st.verifyPhase && st.cur != want)
                next_st.state = S_PG_SETUP;
              else
                advance = 1'b1;
          endcase
        end
      S_PG_SETUP:
        if (tif.done)
          next_st.state = S_PG_PULSE;
      S_PG_PULSE:
        if (tif.done)
          next_st.state = S_PG_HOLD;
      S_PG_HOLD:
        if (tif.done)
        begin
          next_st.verifyPhase = 1'b1;
          next_st.state       = S_RD_SETUP;
        end
      S_PT_SETUP:
        if (tif.done)
          next_st.state = S_PT_PULSE;
      S_PT_PULSE:
        if (tif.done)
          next_st.state = S_PT_HOLD;
      S_PT_HOLD:
        if (tif.done)
          next_st.state = S_DONE;
      S_DONE:
      begin
        next_st.rspValid = 1'b1;
        next_st.state    = S_IDLE;
      end
    endcase
    if (advance)
    begin
      next_st.verifyPhase = 1'b0;
      if (!st.lowByte)
      begin
        next_st.lowByte = 1'b1;
        next_st.state   = S_RD_SETUP;
      end
      else if (st.op == OP_FILL && st.word != '1)
      begin
        next_st.word    = st.word + 1'b1;
        next_st.lowByte = 1'b0;
        next_st.state   = S_RD_SETUP;
      end
      else
      begin
        next_st.allVerified = st.allVerified || (st.op != OP_READ);
        next_st.state       = S_DONE;
      end
    end
    // pin levels follow the next state
    nextWant        = next_st.lowByte ? next_st.data[BYTE_W-1:0] : next_st.data[WORD_W-1:BYTE_W];
    next_st.addr    = {next_st.word, next_st.lowByte};
    next_st.ceOn    = 1'b0;
    next_st.oeOn    = 1'b0;
    next_st.progOn  = 1'b0;
    next_st.protectOn = 1'b0;
    next_st.vppOn   = 1'b0;
    next_st.driveOn = 1'b0;
    next_st.byteOut = ERASED_BYTE;
    unique case (next_st.state)
      S_RD_SETUP, S_RD_EN, S_RD_REL:
      begin
        next_st.ceOn = 1'b1;
        next_st.oeOn = (next_st.state == S_RD_EN);
        if (next_st.op == OP_PROTECT_VERIFY)
        begin
          next_st.protectOn = 1'b1;
          next_st.addr  = PVERIFY_ADDR;
        end
      end
      // data, supply and enables set before the strobe
      // strobe low only within a write
      S_PG_SETUP, S_PG_PULSE, S_PG_HOLD:
      begin
        next_st.ceOn    = 1'b1;
        next_st.vppOn   = 1'b1;
        next_st.driveOn = 1'b1;
        next_st.byteOut = nextWant;
        next_st.progOn  = (next_st.state == S_PG_PULSE);
      end
      // protect bit pulse with chip enable high
      S_PT_SETUP, S_PT_PULSE, S_PT_HOLD:
      begin
        next_st.protectOn = 1'b1;
        next_st.vppOn     = 1'b1;
        next_st.driveOn   = 1'b1;
        next_st.addr      = PROT_ADDR;
        next_st.byteOut   = (next_st.state == S_PT_PULSE) ? LOCK_PULSE : ERASED_BYTE;
      end
      S_IDLE, S_DONE:
        next_st.ceOn = 1'b0;
    endcase
    if (next_st.state != st.state)
    begin
      tif.start = 1'b1;
      tif.load  = waitFor(next_st.state, next_st.algoShort);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign cmdReady          = (st.state == S_IDLE);
  assign rspValid          = st.rspValid;
  assign rspWord           = st.rdData;
  assign rspFail           = st.rspFail;
  assign rspBlocked        = st.rspBlocked;
  assign protectDone       = st.protDone;
  assign byteAddressLines  = st.addr;
  assign chipEnableN       = !st.ceOn;
  assign outputEnableN     = !st.oeOn;
  assign programStrobeN    = !st.progOn;
  assign protectModeSelect = st.protectOn;
  assign highSupplyOn      = st.vppOn;
  assign byteLines         = st.byteOut;
  assign byteLinesOeN      = !st.driveOn;

  // helper counters for the checks below
  logic [CNT_W-1:0] lowCount;
  logic [CNT_W-1:0] oeLowCount;
  logic [CNT_W-1:0] driveCount;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      lowCount   <= '0;
      oeLowCount <= '0;
      driveCount <= '0;
    end
    else
    begin
      lowCount   <= programStrobeN ? '0 : lowCount + 1'b1;
      oeLowCount <= outputEnableN ? '0 : oeLowCount + 1'b1;
      driveCount <= byteLinesOeN ? '0 : driveCount + 1'b1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence strobeFall;
    $fell(programStrobeN);
  endsequence

  sequence strobeEnd;
    $rose(programStrobeN);
  endsequence

  a_strobe_gated: assert property (strobeFall |-> !chipEnableN && outputEnableN && highSupplyOn
    && !byteLinesOeN && driveCount >= SETUP_CYCLES)
    else $error("strobe without setup");
  a_pulse_width: assert property (strobeEnd |-> lowCount == (st.algoShort ? SHORT_PULSE_CYC : FAST_PULSE_CYC))
    else $error("wrong strobe width");
  a_idle_inhibit: assert property (st.state == S_IDLE |-> programStrobeN && chipEnableN && byteLinesOeN)
    else $error("idle not inhibited");
  a_no_contention: assert property (!outputEnableN |-> byteLinesOeN && $past(byteLinesOeN))
    else $error("driving while device drives");
  a_sample_late: assert property (st.state == S_RD_EN && tif.done |-> oeLowCount == OE_EN_CYCLES - 1)
    else $error("sampled too early");
  a_protect_order: assert property ($fell(byteLines[LOCK_POS]) && protectModeSelect |-> st.allVerified
    && !st.failed && chipEnableN && byteAddressLines[PROT_A_POS])
    else $error("protect before clean verify");
  a_verify_follows: assert property (strobeEnd |-> ##[1:1000] !outputEnableN)
    else $error("no verify after write");
  a_clear_only: assert property (strobeFall |-> (byteLines & st.cur) == byteLines)
    else $error("write would raise a bit");
  a_byte_order: assert property (strobeFall |-> byteAddressLines[0] == st.lowByte
    && byteLines == (st.lowByte ? st.data[BYTE_W-1:0] : st.data[WORD_W-1:BYTE_W]))
    else $error("byte order wrong");
  a_word_address: assert property (!chipEnableN && !protectModeSelect |-> byteAddressLines[ADDR_W-1:1] == st.word)
    else $error("address mismatch");
  a_fill_zero: assert property ((strobeFall and (st.op == OP_FILL)) |-> byteLines == 8'h00)
    else $error("fill not zero");

endmodule

// *** tb/eprom_device_model.sv ***
`timescale 1ns/1ps
module eprom_device_model
  import eprom_prog_pkg::*;
#(
  parameter int FAST_CYC  = 20,
  parameter int SHORT_CYC = 10,
  parameter int EN_DELAY  = 10,
  parameter int DIS_DELAY = 10
)
(
  input  wire logic              ref_clk,
  input  wire logic [ADDR_W-1:0] byteAddressLines,
  input  wire logic              chipEnableN,
  input  wire logic              outputEnableN,
  input  wire logic              programStrobeN,
  input  wire logic              protectModeSelect,
  input  wire logic              highSupplyOn,
  input  wire logic              byteLinesOeN,
  input  wire logic [BYTE_W-1:0] byteWire,
  input  wire logic              shortMode,
  output logic [BYTE_W-1:0]      devOut,
  output int                     errCount,
  output int                     pulseCount
);
  logic [BYTE_W-1:0] mem [0:8191];
  logic              readProtect;
  logic [BYTE_W-1:0] noise;
  int                lowCycles;
  int                onCnt;
  int                disCnt;
  int                expCyc;
  logic              devDrive;

  initial
  begin
    for (int i = 0; i < 8192; i++)
      mem[i] = ERASED_BYTE;
    readProtect = 1'b0;
    noise = 8'h5a;
    lowCycles = 0;
    onCnt = 0;
    disCnt = 0;
    errCount = 0;
    pulseCount = 0;
  end

  assign devDrive = !chipEnableN && (!outputEnableN || disCnt != 0);
  assign expCyc = shortMode ? SHORT_CYC : FAST_CYC;

  always_comb
  begin
    devOut = noise;
    if (devDrive && !outputEnableN && onCnt >= EN_DELAY)
    begin
      if (protectModeSelect)
        devOut = {~readProtect, 7'h7f};
      else if (!readProtect)
        devOut = mem[byteAddressLines];
    end
  end

  always @(posedge ref_clk)
  begin
    noise <= noise + 8'h35;
    onCnt <= outputEnableN ? 0 : onCnt + 1;
    disCnt <= !outputEnableN ? DIS_DELAY : (disCnt != 0 ? disCnt - 1 : 0);
    if (!chipEnableN && outputEnableN && !programStrobeN && highSupplyOn && !protectModeSelect)
      mem[byteAddressLines] <= mem[byteAddressLines] & byteWire;
    if (protectModeSelect && chipEnableN && highSupplyOn && byteAddressLines[PROT_A_POS] && !byteWire[LOCK_POS])
      readProtect <= 1'b1;
    if (!programStrobeN)
      lowCycles <= lowCycles + 1;
    else if (lowCycles != 0)
    begin
      pulseCount <= pulseCount + 1;
      if (lowCycles * 100 < expCyc * 95 || lowCycles * 100 > expCyc * 105)
        errCount <= errCount + 1;
      lowCycles <= 0;
    end
    if (devDrive && !byteLinesOeN)
      errCount <= errCount + 1;
  end
endmodule

// *** tb/eprom_programmer_tb_top.sv ***
`timescale 1ns/1ps
module eprom_programmer_tb_top
  import eprom_prog_pkg::*;
;
  logic                   ref_clk;
  logic                   rst_n;
  logic                   cmdValid;
  logic                   cmdReady;
  op_type                 cmdOp;
  logic [WORD_ADDR_W-1:0] cmdWordAddr;
  logic [WORD_W-1:0]      cmdWord;
  logic                   cmdShortPulse;
  logic                   rspValid;
  logic [WORD_W-1:0]      rspWord;
  logic                   rspFail;
  logic                   rspBlocked;
  logic                   protectDone;
  logic [ADDR_W-1:0]      byteAddressLines;
  logic                   chipEnableN;
  logic                   outputEnableN;
  logic                   programStrobeN;
  logic                   protectModeSelect;
  logic                   highSupplyOn;
  logic [BYTE_W-1:0]      byteLines;
  logic                   byteLinesOeN;
  logic [BYTE_W-1:0]      devOut;
  logic [BYTE_W-1:0]      byteWire;
  int                     errCount;
  int                     pulseCount;
  int                     nMismatch;
  int                     comparisons;
  int                     refMem [0:8191];
  int                     refProt;
  int                     refFail;
  int                     refWrote;
  int                     pc;
  logic [11:0]            addrA;
  logic [15:0]            wordA;

  assign byteWire = byteLinesOeN ? devOut : byteLines;

  eprom_programmer #(.FAST_PULSE_CYC(20), .SHORT_PULSE_CYC(10)) eprom_programmer_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp),
    .cmdWordAddr(cmdWordAddr), .cmdWord(cmdWord), .cmdShortPulse(cmdShortPulse), .rspValid(rspValid),
    .rspWord(rspWord), .rspFail(rspFail), .rspBlocked(rspBlocked), .protectDone(protectDone),
    .byteAddressLines(byteAddressLines), .chipEnableN(chipEnableN), .outputEnableN(outputEnableN),
    .programStrobeN(programStrobeN), .protectModeSelect(protectModeSelect), .highSupplyOn(highSupplyOn),
    .byteLines(byteLines), .byteLinesIn(byteWire), .byteLinesOeN(byteLinesOeN));

  eprom_device_model #(.FAST_CYC(20), .SHORT_CYC(10)) eprom_device_model_inst (
    .ref_clk(ref_clk), .byteAddressLines(byteAddressLines), .chipEnableN(chipEnableN),
    .outputEnableN(outputEnableN), .programStrobeN(programStrobeN), .protectModeSelect(protectModeSelect),
    .highSupplyOn(highSupplyOn), .byteLinesOeN(byteLinesOeN), .byteWire(byteWire), .shortMode(cmdShortPulse),
    .devOut(devOut), .errCount(errCount), .pulseCount(pulseCount));

  always #2.5 ref_clk = ~ref_clk;

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, nMismatch);
    if (nMismatch == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic run_cmd(input op_type op, input logic [11:0] wa, input logic [15:0] w, input logic sp);
    int n;
    n = 0;
    while (cmdReady !== 1'b1 && n < 100)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 100)
    begin
      nMismatch++;
      print_verdict();
    end
    cmdValid = 1'b1;
    cmdOp = op;
    cmdWordAddr = wa;
    cmdWord = w;
    cmdShortPulse = sp;
    @(negedge ref_clk);
    cmdValid = 1'b0;
    n = 0;
    while (rspValid !== 1'b1 && n < 40000)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 40000)
    begin
      nMismatch++;
      print_verdict();
    end
  endtask

  task automatic do_reset();
    @(negedge ref_clk);
    rst_n = 1'b0;
    repeat (10) @(negedge ref_clk);
    rst_n = 1'b1;
    refFail = 0;
    refWrote = 0;
    check("idle", 16'h001e, {11'h0, cmdReady, chipEnableN, programStrobeN, byteLinesOeN, highSupplyOn});
    $display("test reset done");
  endtask

  task automatic do_read(input logic [11:0] wa);
    run_cmd(OP_READ, wa, 16'h0, 1'b0);
    check("blocked", 16'(refProt), 16'(rspBlocked));
    if (refProt == 0)
      check("read word", 16'((refMem[wa * 2] << 8) | refMem[wa * 2 + 1]), rspWord);
    $display("test read %h done", wa);
  endtask

  task automatic do_write(input logic [11:0] wa, input logic [15:0] w, input logic sp);
    int want;
    int fail;
    fail = 0;
    for (int b = 0; b < 2; b++)
    begin
      want = b ? w[7:0] : w[15:8];
      if ((refMem[wa * 2 + b] & want) != want)
        fail = 1;
      else
        refMem[wa * 2 + b] = want;
    end
    run_cmd(OP_WRITE, wa, w, sp);
    check("write fail", 16'(fail), 16'(rspFail));
    if (fail != 0)
      refFail = 1;
    else
      refWrote = 1;
    for (int b = 0; b < 2; b++)
      check("cell", 16'(refMem[wa * 2 + b]), 16'(eprom_device_model_inst.mem[wa * 2 + b]));
    $display("test write %h done", wa);
  endtask

  task automatic do_protect();
    int fail;
    fail = (refFail != 0 || refWrote == 0) ? 1 : 0;
    run_cmd(OP_PROTECT, 12'h0, 16'h0, 1'b0);
    check("protect fail", 16'(fail), 16'(rspFail));
    if (fail == 0)
      refProt = 1;
    run_cmd(OP_PROTECT_VERIFY, 12'h0, 16'h0, 1'b0);
    check("protect done", 16'(refProt), 16'(protectDone));
    $display("test protect done");
  endtask

  initial
  begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    cmdValid = 1'b0;
    cmdOp = OP_READ;
    cmdWordAddr = 12'h0;
    cmdWord = 16'h0;
    cmdShortPulse = 1'b0;
    nMismatch = 0;
    comparisons = 0;
    refProt = 0;
    pc = $urandom(32'h3ff6c8e9);
    for (int i = 0; i < 8192; i++)
      refMem[i] = 255;
    addrA = 12'($urandom % 4000) + 12'h1;
    wordA = 16'($urandom) & 16'hfefe;
    do_reset();
    do_protect();
    do_read(addrA);
    do_write(addrA, wordA, 1'b0);
    do_read(addrA);
    pc = pulseCount;
    do_write(addrA, wordA, 1'b0);
    check("no extra pulse", 16'(pc), 16'(pulseCount));
    do_write(addrA ^ 12'h800, 16'($urandom) & 16'h7f7f, 1'b1);
    do_read(addrA ^ 12'h800);
    do_write(addrA, wordA | 16'h0001, 1'b0);
    do_protect();
    do_reset();
    run_cmd(OP_FILL, 12'hffe, 16'h0, 1'b1);
    refMem[8188] = 0;
    refMem[8189] = 0;
    refMem[8190] = 0;
    refMem[8191] = 0;
    refWrote = 1;
    check("fill fail", 16'h0, 16'(rspFail));
    $display("test fill done");
    do_read(12'hfff);
    do_read(12'hffe);
    do_protect();
    do_read(addrA);
    check("device rules", 16'h0, 16'(errCount));
    print_verdict();
  end
endmodule
